// ==== verilog/mcd_core.sv ====
/*
 * Instruction decode and sequencing core with an AHB-Lite register slave.
 * Assumes program memory answers instr_word for instr_pointer within one
 * clock; all inputs synchronous to clk_sys.
 */
// Decided for this implementation: register access over AHB-Lite and the register offsets.
// Functional notes
// RQ1 - Each instruction is one 14-bit word of opcode plus operand fields.
// RQ2 - Every word falls in exactly one of byte, bit, or literal/control format.
// RQ3 - Byte operations store to the accumulator when d is 0, to the file when d is 1.
// RQ4 - The file address is seven bits covering 0x00 to 0x7F.
// RQ5 - Bit operations pick one bit of the addressed 8-bit file register.
// RQ6 - Literal operations take an 8-bit or 11-bit constant from the word.
// RQ7 - One instruction cycle lasts four oscillator periods.
// RQ8 - A true skip or a pointer change costs a second cycle run as a no-op.
// RQ9 - Every file access reads first, then modifies and stores.
// RQ10 - Clearing the second port reads it first, which clears its mismatch.
// RQ11 - Don't-care bits of a word are ignored; software should emit zeros.
// RQ12 - Software should avoid the prescaler and direction-load words.
// RQ13 - The core keeps a time-out flag and a power-down flag.
// RQ14 - Format and opcode boundaries follow the general format layout.
`timescale 1ns/10ps
module mcd_core
  import mcd_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_D
)(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [WORD_W-1:0] instr_word,
  output logic [PTR_W-1:0]       instr_pointer,
  input  wire logic [7:0]        port_in,
  output logic [7:0]             port_out,
  output logic                   port_change_int_flag,
  output logic                   timeout_flag,
  output logic                   powerdown_flag,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  logic [1:0]        phase, next_phase;
  logic [WORD_W-1:0] ir, next_ir;
  logic              squash, next_squash;
  logic              rd_done, next_rd_done;
  logic [7:0]        rd_q, next_rd_q;
  logic [7:0]        w_acc, next_w_acc;
  logic              carry, next_carry;
  logic [7:0]        file_mem [128], next_file [128];
  logic [PTR_W-1:0]  stack [STACK_DEPTH], next_stack [STACK_DEPTH];
  logic [SP_W-1:0]   sp, next_sp;
  logic [PTR_W-1:0]  next_ptr;
  logic [7:0]        port_snap, next_port_snap, next_port_out;
  logic              next_pcf, next_to, next_pd, asleep, next_asleep;
  logic              run, fetched, next_fetched;
  logic              ctrl_wr, stat_clr;
  mcd_dec_t          dec;
  logic              exec_now;
  logic [7:0]        res;
  logic              wr_w, wr_f, take_extra;

  mcd_decode u_dec (
    .iw  (ir),
    .dec (dec)
  );

  // RQ7 divide by four, execute on the last phase
  // Only a word fetched this cycle runs, so a mid-cycle start or wake never repeats a stale word
  assign exec_now = (phase == PH_EXEC) && run && !asleep && fetched;

  always_comb begin
    res        = rd_q;
    wr_w       = 1'b0;
    wr_f       = 1'b0;
    take_extra = 1'b0;
    next_carry = carry;
    next_ptr   = instr_pointer + 13'h1;
    next_sp    = sp;
    next_stack = stack;
    next_to    = timeout_flag;
    next_pd    = powerdown_flag;
    next_asleep = asleep && !ctrl_wr;
    // RQ3 byte results routed by d
    if (dec.fmt == FMT_BYTE) begin
      wr_w = !dec.dest;
      wr_f = dec.dest;
    end
    case (dec.op)
      OP_MOVWF: res = w_acc;
      OP_CLR:   res = 8'h00;
      OP_CLRW: begin
        res  = 8'h00;
        wr_w = 1'b1;
      end
      OP_SUB:   res = rd_q - w_acc;
      OP_DEC:   res = rd_q - 8'h01;
      OP_IOR:   res = rd_q | w_acc;
      OP_AND:   res = rd_q & w_acc;
      OP_XOR:   res = rd_q ^ w_acc;
      OP_ADD:   res = rd_q + w_acc;
      OP_COM:   res = ~rd_q;
      OP_INC:   res = rd_q + 8'h01;
      OP_DECSZ: begin
        res        = rd_q - 8'h01;
        take_extra = (res == 8'h00);
      end
      OP_INCSZ: begin
        res        = rd_q + 8'h01;
        take_extra = (res == 8'h00);
      end
      OP_RR: begin
        res        = {carry, rd_q[7:1]};
        next_carry = rd_q[0];
      end
      OP_RL: begin
        res        = {rd_q[6:0], carry};
        next_carry = rd_q[7];
      end
      OP_SWAP:  res = {rd_q[3:0], rd_q[7:4]};
      // RQ5 single bit chosen by bsel
      OP_BCLR: begin
        res          = rd_q;
        res[dec.bsel] = 1'b0;
        wr_f         = 1'b1;
      end
      OP_BSET: begin
        res          = rd_q;
        res[dec.bsel] = 1'b1;
        wr_f         = 1'b1;
      end
      OP_BTSC:  take_extra = !rd_q[dec.bsel];
      OP_BTSS:  take_extra = rd_q[dec.bsel];
      // RQ6 literal operands
      OP_MOVL, OP_RETL, OP_IORL, OP_ANDL, OP_XORL, OP_SUBL, OP_ADDL: begin
        wr_w = 1'b1;
        case (dec.op)
          OP_IORL: res = dec.k8 | w_acc;
          OP_ANDL: res = dec.k8 & w_acc;
          OP_XORL: res = dec.k8 ^ w_acc;
          OP_SUBL: res = dec.k8 - w_acc;
          OP_ADDL: res = dec.k8 + w_acc;
          default: res = dec.k8;
        endcase
      end
      OP_CALL, OP_GOTO: begin
        take_extra = 1'b1;
        next_ptr   = {instr_pointer[PTR_W-1:11], dec.k11};
      end
      OP_RET, OP_RETI: take_extra = 1'b1;
      // RQ13 flag updates
      OP_CLRWDT: begin
        next_to = 1'b1;
        next_pd = 1'b1;
      end
      OP_SLEEP: begin
        next_to     = 1'b1;
        next_pd     = 1'b0;
        next_asleep = 1'b1;
      end
      // RQ12 recognised but no option or direction latch exists here
      default: res = rd_q;
    endcase
    if (dec.op == OP_RETL) begin
      take_extra = 1'b1;
    end
    if (dec.op == OP_CALL) begin
      next_stack[sp] = instr_pointer + 13'h1;
      next_sp        = sp + 1'b1;
    end
    if (dec.op == OP_RET || dec.op == OP_RETI || dec.op == OP_RETL) begin
      next_sp  = sp - 1'b1;
      next_ptr = stack[sp - 1'b1];
    end
    // RQ8 skip jumps past the next word, whose slot becomes the no-op
    if (take_extra && dec.fmt != FMT_LIT) begin
      next_ptr = instr_pointer + 13'h2;
    end
  end

  always_comb begin
    next_phase     = phase + 2'h1;
    next_ir        = ir;
    next_squash    = squash;
    next_rd_done   = rd_done;
    next_rd_q      = rd_q;
    next_w_acc     = w_acc;
    next_file      = file_mem;
    next_port_snap = port_snap;
    next_port_out  = port_out;
    next_fetched   = fetched;
    // Set wins over a software clear in the same cycle
    next_pcf = (port_change_int_flag && !stat_clr) || (port_in != port_snap);
    if (run && !asleep && phase == PH_FETCH) begin
      next_ir      = instr_word;
      next_fetched = 1'b1;
    end
    // RQ9 read phase ahead of every file store
    if (run && !asleep && fetched && phase == PH_READ && dec.uses_file && !squash) begin
      next_rd_done = 1'b1;
      if (dec.fadr == PORT2_ADR) begin
        // RQ10 port read resyncs the mismatch reference
        next_rd_q      = port_in;
        next_port_snap = port_in;
      end else begin
        next_rd_q = file_mem[dec.fadr];
      end
    end
    if (exec_now) begin
      next_fetched = 1'b0;
      next_rd_done = 1'b0;
      next_squash  = 1'b0;
      if (!squash) begin
        next_squash = take_extra;
        if (wr_w) begin
          next_w_acc = res;
        end
        if (wr_f) begin
          if (dec.fadr == PORT2_ADR) begin
            next_port_out = res;
          end else begin
            next_file[dec.fadr] = res;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase    <= PH_FETCH;
      ir       <= '0;
      squash   <= 1'b0;
      rd_done  <= 1'b0;
      rd_q     <= '0;
      w_acc    <= '0;
      carry    <= 1'b0;
      file_mem <= '{default: 8'h00};
      stack    <= '{default: '0};
      sp       <= '0;
      instr_pointer        <= '0;
      port_snap            <= '0;
      port_out             <= '0;
      port_change_int_flag <= 1'b0;
      timeout_flag         <= FLAG_RST;
      powerdown_flag       <= FLAG_RST;
      asleep               <= 1'b0;
      fetched              <= 1'b0;
    end else begin
      phase    <= next_phase;
      ir       <= next_ir;
      squash   <= next_squash;
      rd_done  <= next_rd_done;
      rd_q     <= next_rd_q;
      w_acc    <= next_w_acc;
      file_mem <= next_file;
      port_snap            <= next_port_snap;
      port_out             <= next_port_out;
      port_change_int_flag <= next_pcf;
      fetched              <= next_fetched;
      asleep               <= exec_now && !squash ? next_asleep : asleep && !ctrl_wr;
      // RQ8 no-op slot keeps the pointer so its target is fetched again
      if (exec_now && !squash) begin
        carry          <= next_carry;
        stack          <= next_stack;
        sp             <= next_sp;
        instr_pointer  <= next_ptr;
        timeout_flag   <= next_to;
        powerdown_flag <= next_pd;
      end
    end
  end

  // Register slave: zero wait states, always OKAY
  logic        dp_valid, next_dp_valid, dp_write, next_dp_write;
  logic [7:0]  dp_addr, next_dp_addr;
  logic [31:0] next_hrdata;
  logic        next_run;

  always_comb begin
    next_dp_valid = hsel && htrans == HTRANS_NONSEQ && hready;
    next_dp_write = hwrite;
    next_dp_addr  = haddr[7:0];
    next_hrdata   = hrdata;
    next_run      = run;
    ctrl_wr  = dp_valid && dp_write && dp_addr == REG_CTRL;
    stat_clr = dp_valid && dp_write && dp_addr == REG_STAT && hwdata[STAT_PCF_BIT];
    if (ctrl_wr) begin
      next_run = hwdata[CTRL_RUN_BIT];
    end
    if (next_dp_valid && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      case (haddr[7:0])
        REG_CTRL: next_hrdata[CTRL_RUN_BIT] = run;
        REG_STAT: begin
          next_hrdata[STAT_TO_BIT]  = timeout_flag;
          next_hrdata[STAT_PD_BIT]  = powerdown_flag;
          next_hrdata[STAT_PCF_BIT] = port_change_int_flag;
          next_hrdata[STAT_SLP_BIT] = asleep;
        end
        REG_WACC: next_hrdata[7:0]       = w_acc;
        REG_PTR:  next_hrdata[PTR_W-1:0] = instr_pointer;
        default:  next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      run       <= RUN_RST;
    end else begin
      dp_valid  <= next_dp_valid;
      dp_write  <= next_dp_write;
      dp_addr   <= next_dp_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      run       <= next_run;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_three_idle;
    (phase != PH_EXEC) [*3];
  endsequence
  a_cycle_four_osc: assert property ( // RQ7
    phase == PH_EXEC |=> s_three_idle ##1 phase == PH_EXEC)
    else $error("instruction cycle is not four clocks");
  a_dest_acc: assert property ( // RQ3
    exec_now && !squash && dec.fmt == FMT_BYTE && !dec.dest && dec.op != OP_MOVWF
    && dec.op != OP_CLR |=> w_acc == $past(res))
    else $error("d=0 result not in accumulator");
  a_dest_file: assert property ( // RQ3
    exec_now && !squash && dec.fmt == FMT_BYTE && dec.dest && dec.fadr != PORT2_ADR
    |=> file_mem[$past(dec.fadr)] == $past(res) && w_acc == $past(w_acc))
    else $error("d=1 result not in file");
  a_read_first: assert property ( // RQ9
    exec_now && !squash && dec.uses_file |-> rd_done)
    else $error("file store without prior read");
  a_extra_nop: assert property ( // RQ8
    exec_now && !squash && take_extra |=> squash [*4])
    else $error("second cycle not squashed");
  a_nop_quiet: assert property ( // RQ8
    exec_now && squash |=> w_acc == $past(w_acc) && !squash)
    else $error("squashed cycle changed state");
  a_port_clear: assert property ( // RQ10
    exec_now && !squash && dec.op == OP_CLR && dec.fadr == PORT2_ADR
    |-> port_snap == $past(port_in, 2) ##1 port_out == 8'h00)
    else $error("port clear lacked read then zero write");
  a_bit_set: assert property ( // RQ5
    exec_now && !squash && dec.op == OP_BSET && dec.fadr != PORT2_ADR
    |=> file_mem[$past(dec.fadr)][$past(dec.bsel)])
    else $error("bit set missed selected bit");
  a_goto_lit: assert property ( // RQ6
    exec_now && !squash && dec.op == OP_GOTO |=> instr_pointer[10:0] == $past(dec.k11))
    else $error("jump target not the 11-bit literal");
  a_clrwdt_flags: assert property ( // RQ13
    exec_now && !squash && dec.op == OP_CLRWDT |=> timeout_flag && powerdown_flag)
    else $error("watchdog clear did not set flags");
endmodule

// ==== verilog/mcd_pkg.sv ====
/*
 * Shared constants and types for the instruction decode core.
 * Assumes one 125 MHz clock and a synchronous active-high reset.
 */
package mcd_pkg;
  localparam int WORD_W        = 14;
  localparam int FADR_W        = 7;
  localparam int PTR_W         = 13;
  localparam int STACK_D       = 8;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_READ  = 2'h1;
  localparam logic [1:0] PH_EXEC  = 2'h3;
  localparam logic [6:0] PORT2_ADR = 7'h06;
  // Bus map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WACC = 8'h08;
  localparam logic [7:0] REG_PTR  = 8'h0C;
  localparam int CTRL_RUN_BIT  = 0;
  localparam int STAT_TO_BIT   = 0;
  localparam int STAT_PD_BIT   = 1;
  localparam int STAT_PCF_BIT  = 2;
  localparam int STAT_SLP_BIT  = 3;
  localparam logic       RUN_RST   = 1'b0;
  localparam logic       FLAG_RST  = 1'b1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {FMT_BYTE, FMT_BIT, FMT_LIT} mcd_fmt_t;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOVWF, OP_CLR, OP_CLRW, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
    OP_ADD, OP_MOV, OP_COM, OP_INC, OP_DECSZ, OP_RR, OP_RL, OP_SWAP, OP_INCSZ,
    OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS, OP_CALL, OP_GOTO, OP_MOVL, OP_RETL,
    OP_IORL, OP_ANDL, OP_XORL, OP_SUBL, OP_ADDL, OP_RET, OP_RETI, OP_CLRWDT,
    OP_SLEEP, OP_OPTN, OP_DIRLD
  } mcd_op_t;

  typedef struct packed {
    mcd_fmt_t    fmt;
    mcd_op_t     op;
    logic        uses_file;
    logic [6:0]  fadr;
    logic        dest;
    logic [2:0]  bsel;
    logic [7:0]  k8;
    logic [10:0] k11;
  } mcd_dec_t;
endpackage

// ==== verilog/mcd_decode.sv ====
/*
 * Pure decoder: splits one 14-bit instruction word into format,
 * operation and operand fields. Assumes the word is already registered.
 */
`timescale 1ns/10ps
module mcd_decode
  import mcd_pkg::*;
(
  input  wire logic [WORD_W-1:0] iw,
  output mcd_dec_t               dec
);
  always_comb begin
    dec           = '0;
    // RQ1 RQ4 RQ5 RQ6 field extraction
    dec.fadr      = iw[6:0];
    dec.dest      = iw[7];
    dec.bsel      = iw[9:7];
    dec.k8        = iw[7:0];
    dec.k11       = iw[10:0];
    dec.fmt       = FMT_LIT;
    dec.op        = OP_NOP;
    dec.uses_file = 1'b0;
    // RQ2 RQ14 format split on top bits
    case (iw[13:12])
      2'h0: begin
        dec.fmt       = FMT_BYTE;
        dec.uses_file = 1'b1;
        case (iw[11:8])
          4'h0: begin
            if (iw[7]) begin
              dec.op = OP_MOVWF;
            end else begin
              // RQ11 control words, don't-care bits ignored
              dec.fmt       = FMT_LIT;
              dec.uses_file = 1'b0;
              case (iw[6:0])
                7'h08:   dec.op = OP_RET;
                7'h09:   dec.op = OP_RETI;
                7'h62:   dec.op = OP_OPTN;
                7'h63:   dec.op = OP_SLEEP;
                7'h64:   dec.op = OP_CLRWDT;
                7'h65,
                7'h66,
                7'h67:   dec.op = OP_DIRLD;
                default: dec.op = OP_NOP;
              endcase
            end
          end
          4'h1: begin
            // RQ11 low seven bits of the accumulator clear are ignored
            dec.op        = iw[7] ? OP_CLR : OP_CLRW;
            dec.uses_file = iw[7];
          end
          4'h2:    dec.op = OP_SUB;
          4'h3:    dec.op = OP_DEC;
          4'h4:    dec.op = OP_IOR;
          4'h5:    dec.op = OP_AND;
          4'h6:    dec.op = OP_XOR;
          4'h7:    dec.op = OP_ADD;
          4'h8:    dec.op = OP_MOV;
          4'h9:    dec.op = OP_COM;
          4'hA:    dec.op = OP_INC;
          4'hB:    dec.op = OP_DECSZ;
          4'hC:    dec.op = OP_RR;
          4'hD:    dec.op = OP_RL;
          4'hE:    dec.op = OP_SWAP;
          default: dec.op = OP_INCSZ;
        endcase
      end
      2'h1: begin
        dec.fmt       = FMT_BIT;
        dec.uses_file = 1'b1;
        case (iw[11:10])
          2'h0:    dec.op = OP_BCLR;
          2'h1:    dec.op = OP_BSET;
          2'h2:    dec.op = OP_BTSC;
          default: dec.op = OP_BTSS;
        endcase
      end
      2'h2: dec.op = iw[11] ? OP_GOTO : OP_CALL;
      default: begin
        // RQ11 unused literal-space bits ignored
        casez (iw[11:8])
          4'b00??: dec.op = OP_MOVL;
          4'b01??: dec.op = OP_RETL;
          4'b1000: dec.op = OP_IORL;
          4'b1001: dec.op = OP_ANDL;
          4'b1010: dec.op = OP_XORL;
          4'b110?: dec.op = OP_SUBL;
          default: dec.op = OP_ADDL;
        endcase
      end
    endcase
  end
endmodule

// ==== verification/mcd_prog_mem.sv ====
/*
 * Program memory model feeding the decode core one word per pointer value.
 * Assumes the bench loads rom directly and that the core samples the word
 * on the rising edge after it moves the pointer; the word turns on the
 * falling edge between, so it is valid within one clock.
 */
`timescale 1ns/10ps
module mcd_prog_mem
  import mcd_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic [PTR_W-1:0] instr_pointer,
  output logic [WORD_W-1:0]     instr_word
);
  logic [WORD_W-1:0] rom [0:255];

  initial instr_word = '0;

  // words as loaded
  // The bench chooses spare bits and avoided words; out of range toggles
  // so a stale word never passes for a valid one
  always_ff @(negedge clk_sys) begin
    if (instr_pointer[PTR_W-1:8] != '0)
      instr_word <= ~instr_word;
    else
      instr_word <= rom[instr_pointer[7:0]];
  end
endmodule

// ==== verification/test_mcd_core.sv ====
/*
 * Self-checking bench for the decode core: runs small programs and
 * watches the port, flags and registers.
 * Assumes one 125 MHz clock and that port_in is read by file accesses.
 */
`timescale 1ns/10ps
module test_mcd_core
  import mcd_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic [WORD_W-1:0] instr_word;
  logic [PTR_W-1:0]  instr_pointer;
  logic [7:0]        port_in = 8'h00;
  logic [7:0]        port_out;
  logic              port_change_int_flag;
  logic              timeout_flag;
  logic              powerdown_flag;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h0;
  logic [31:0]       hwdata = 32'h0;
  wire logic         hready;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  int                cyc = 0;
  int                fails = 0;
  int                n_compared = 0;
  logic [7:0]        last_port = 8'h00;
  int                chg_t [$];
  logic [7:0]        chg_v [$];

  assign hready = hreadyout;

  always #4 clk_sys = ~clk_sys;

  mcd_core #(.STACK_DEPTH(STACK_D)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .instr_word(instr_word),
    .instr_pointer(instr_pointer), .port_in(port_in), .port_out(port_out),
    .port_change_int_flag(port_change_int_flag), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
  );

  mcd_prog_mem pm (
    .clk_sys(clk_sys), .instr_pointer(instr_pointer), .instr_word(instr_word)
  );

  // Ceiling well above the several hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      stop_test();
    end
  end

  // Record every change of port_out with its cycle for spacing checks
  always @(posedge clk_sys) begin
    if (port_out !== last_port) begin
      chg_t.push_back(cyc);
      chg_v.push_back(port_out);
    end
    last_port <= port_out;
  end

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    check(v, exp, what);
    check(hresp, 32'h0, "okay response");
  endtask

  task automatic reset_load(input logic [WORD_W-1:0] p [$]);
    sys_rst <= 1'b1;
    for (int i = 0; i < 256; i++)
      pm.rom[i] = (i < p.size()) ? p[i] : 14'h0000;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chg_t.delete();
    chg_v.delete();
  endtask

  // Starts (or wakes) the core and waits for n changes of port_out
  task automatic run_wait(input int n);
    int k;
    wr(REG_CTRL, 32'h1);
    k = 0;
    while (chg_v.size() < n && k < 400) begin
      @(posedge clk_sys);
      k++;
    end
    check(32'(chg_v.size()), 32'(n), "port store count");
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic gap(input int i, input int clocks);
    check(32'(chg_t[i] - chg_t[i-1]), 32'(clocks), "store spacing");
  endtask

  task automatic t_reset();
    check(instr_pointer, 32'h0, "pointer");
    check({timeout_flag, powerdown_flag, port_change_int_flag}, 32'h6, "flag pins");
    rd_chk(REG_STAT, 32'h3, "status");
    rd_chk(REG_CTRL, 32'h0, "ctrl");
    rd_chk(REG_PTR, 32'h0, "pointer reg");
    wr(REG_WACC, 32'h000000FF);
    rd_chk(REG_WACC, 32'h0, "acc read-only");
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0, "unmapped");
    rd_chk(REG_CTRL, 32'h0, "ctrl after unmapped");
  endtask

  // Spare bits set in the literal word; no direction-load word is issued
  task automatic t_bytes();
    port_in <= 8'h5A;
    reset_load({14'h335A, 14'h0086, 14'h0706, 14'h0586, 14'h0000, 14'h00FF,
                14'h3000, 14'h087F, 14'h15FF, 14'h087F});
    run_wait(2);
    check(chg_v[0], 32'h5A, "literal store");
    check(chg_v[1], 32'h10, "and to file");
    gap(1, 2 * OSC_PER_CYCLE);
    // Wait until the file copy has reloaded the accumulator
    repeat (8) @(posedge clk_sys);
    rd_chk(REG_WACC, 32'hB4, "file at 7F to acc");
    rd_chk(REG_CTRL, 32'h1, "ctrl readback");
    repeat (8) @(posedge clk_sys);
    rd_chk(REG_WACC, 32'hBC, "bit set in file");
  endtask

  // Jump, taken skip and untaken skip between port stores
  task automatic t_flow();
    port_in <= 8'h00;
    reset_load({14'h3001, 14'h0086, 14'h2804, 14'h3077, 14'h3002, 14'h0086, 14'h1B86,
                14'h3099, 14'h3003, 14'h0086, 14'h1F86, 14'h3004, 14'h0086});
    run_wait(4);
    check({chg_v[0], chg_v[1], chg_v[2], chg_v[3]}, 32'h01020304, "flow values");
    gap(1, 16);
    gap(2, 16);
    gap(3, 12);
  endtask

  task automatic t_bits();
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      port_in <= 8'hFF;
      reset_load({14'h1006 | 14'(b << 7)});
      run_wait(1);
      e = ~(8'h01 << b);
      check(chg_v[0], e, "bit clear");
      port_in <= 8'h00;
      reset_load({14'h1406 | 14'(b << 7)});
      run_wait(1);
      e = 8'h01 << b;
      check(chg_v[0], e, "bit set");
    end
  endtask

  task automatic t_port_flag();
    port_in <= 8'h00;
    reset_load({14'h3081, 14'h0086, 14'h0186});
    port_in <= 8'h33;
    repeat (4) @(posedge clk_sys);
    check(port_change_int_flag, 32'h1, "mismatch sets flag");
    wr(REG_STAT, 32'h4);
    repeat (2) @(posedge clk_sys);
    check(port_change_int_flag, 32'h1, "flag holds on mismatch");
    run_wait(2);
    check({chg_v[0], chg_v[1]}, 32'h8100, "store then clear");
    wr(REG_STAT, 32'h4);
    repeat (4) @(posedge clk_sys);
    check(port_change_int_flag, 32'h0, "read ended mismatch");
    rd_chk(REG_STAT, 32'h3, "status after clear");
  endtask

  task automatic t_sleep();
    port_in <= 8'h00;
    reset_load({14'h0063, 14'h3042, 14'h0086, 14'h0064});
    run_wait(0);
    check({timeout_flag, powerdown_flag}, 32'h2, "asleep flags");
    check(port_out, 32'h0, "halted");
    rd_chk(REG_STAT, 32'h9, "asleep status");
    run_wait(1);
    check(chg_v[0], 32'h42, "woken store");
    check({timeout_flag, powerdown_flag}, 32'h3, "watchdog clear flags");
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_bytes();
    t_flow();
    t_bits();
    t_port_flag();
    t_sleep();
    stop_test();
  end
endmodule
